// >>> rtl/eat_ctrl.sv
// Functional notes
// - Hold 12-bit humidity result in two bytes
// - Log high byte always, low byte if wide
// - Wide humidity format bit selects log width
// - Humidity alarms compare only the result MSB
// - Humidity low/high thresholds readable and writable
// - Compare raw result, no correction applied
// - Temperature thresholds; flags in alarm status
// - Temperature high alarm when enabled, >= threshold
// - Temperature low alarm when enabled, <= threshold
// - Humidity high alarm when enabled, >= threshold
// - Humidity low alarm when enabled, <= threshold
// - Humidity flags share the alarm status register
// - Temp/oscillator control bits 7..2 read zero
// - Humidity control bits 7..2 read one
// - Control registers read-only during a mission
// - Fast select: seconds if set, else minutes
// - Oscillator enable beside sample speed select
// - Oscillator enable; conversion or start sets it
// - 14-bit interval, zero acts as one
`timescale 1ns/10ps
module eat_ctrl import eat_pkg::*; #(
	parameter int SEC_CYCLES = EAT_SEC_CYCLES
) (
	input wire logic REF_CLK,
	input wire logic RESET,
	input wire logic [11:0] AVS_ADDRESS,
	input wire logic AVS_READ,
	input wire logic AVS_WRITE,
	input wire logic [31:0] AVS_WRITEDATA,
	input wire logic [3:0] AVS_BYTEENABLE,
	output logic [31:0] AVS_READDATA,
	output logic AVS_WAITREQUEST,
	input wire logic MISSION_ACTIVE,
	input wire logic MISSION_START,
	input wire logic FORCED_CONV,
	input wire logic MEM_CLEAR,
	input wire logic TEMP_CONV_VALID,
	input wire logic [7:0] TEMP_CONV_MSB,
	input wire logic HUM_CONV_VALID,
	input wire logic [11:0] HUM_CONV_RESULT,
	output logic OSC_RUN,
	output logic FAST_SAMPLE,
	output logic SAMPLE_DUE,
	output logic LOG_HUM_WR,
	output logic LOG_HUM_WIDE,
	output logic [15:0] LOG_HUM_DATA,
	output logic ALARM_ANY
);

	// Whole register state of the block
	typedef struct packed {
		eat_bus_e bus;
		logic waitreq;
		logic [7:0] rdata;
		logic [7:0] temp_lo_thr;
		logic [7:0] temp_hi_thr;
		logic [7:0] hum_lo_thr;
		logic [7:0] hum_hi_thr;
		logic [11:0] hum_result;
		logic temp_high_alarm_en;
		logic temp_low_alarm_en;
		logic hum_high_alarm_en;
		logic hum_low_alarm_en;
		logic fast_sample_sel;
		logic osc_run_en;
		logic [13:0] rate;
		logic [5:0] mission_cfg;
		logic temp_low_flag;
		logic temp_high_flag;
		logic hum_low_flag;
		logic hum_high_flag;
		logic bor_flag;
		logic log_wr;
		logic log_wide;
		logic [15:0] log_data;
		logic alarm_any;
	} eat_state_s;

	eat_state_s state_reg;
	eat_state_s state_next;

	logic bus_req;
	logic [9:0] reg_idx;
	logic [7:0] wr_byte;
	logic [7:0] hum_result_msb;
	logic [3:0] hum_result_lsb;
	logic hum_wide_format_sel;
	logic hum_log_en;
	logic timer_run;
	logic timer_due;

	assign bus_req = AVS_READ || AVS_WRITE;
	assign reg_idx = AVS_ADDRESS[11:2];
	assign wr_byte = AVS_WRITEDATA[7:0];
	assign hum_result_msb = state_reg.hum_result[11:4];
	assign hum_result_lsb = state_reg.hum_result[3:0];
	assign hum_wide_format_sel = state_reg.mission_cfg[EAT_HUM_WIDE_BIT];
	assign hum_log_en = state_reg.mission_cfg[EAT_HUM_LOG_BIT];

	// Sample time base only runs while the oscillator runs during a mission
	assign timer_run = state_reg.osc_run_en && MISSION_ACTIVE;

	eat_sample_timer #(
		.SEC_CYCLES(SEC_CYCLES)
	) u_timer (
		.clk(REF_CLK),
		.rst(RESET),
		.run_en(timer_run),
		.fast_sel(state_reg.fast_sample_sel),
		.interval(state_reg.rate),
		.sample_due(timer_due)
	);

	// Next-state logic: bus slave, conversions, alarms and logging
	always_comb begin
		logic [7:0] rd;
		logic [7:0] hum_msb_new;
		rd = 8'h00;
		hum_msb_new = HUM_CONV_RESULT[11:4];
		state_next = state_reg;
		state_next.log_wr = 1'b0;

		// Read multiplexer; unmapped addresses read as zero
		case (reg_idx)
			EAT_IDX_RATE_LO: begin
				rd = state_reg.rate[7:0];
			end
			EAT_IDX_RATE_HI: begin
				rd = {2'b00, state_reg.rate[13:8]};
			end
			EAT_IDX_TEMP_LO_THR: begin
				rd = state_reg.temp_lo_thr;
			end
			EAT_IDX_TEMP_HI_THR: begin
				rd = state_reg.temp_hi_thr;
			end
			EAT_IDX_HUM_LO_THR: begin
				rd = state_reg.hum_lo_thr;
			end
			EAT_IDX_HUM_HI_THR: begin
				rd = state_reg.hum_hi_thr;
			end
			EAT_IDX_HUM_RES_LSB: begin
				// Lower nibble carries nothing from the sensor; shown as zero
				rd = {hum_result_lsb, 4'h0};
			end
			EAT_IDX_HUM_RES_MSB: begin
				rd = hum_result_msb;
			end
			EAT_IDX_TEMP_CTRL: begin
				rd = EAT_TEMP_CTRL_FILL;
				rd[EAT_HIGH_EN_BIT] = state_reg.temp_high_alarm_en;
				rd[EAT_LOW_EN_BIT] = state_reg.temp_low_alarm_en;
			end
			EAT_IDX_HUM_CTRL: begin
				rd = EAT_HUM_CTRL_FILL;
				rd[EAT_HIGH_EN_BIT] = state_reg.hum_high_alarm_en;
				rd[EAT_LOW_EN_BIT] = state_reg.hum_low_alarm_en;
			end
			EAT_IDX_OSC_CTRL: begin
				rd = EAT_OSC_CTRL_FILL;
				rd[EAT_FAST_BIT] = state_reg.fast_sample_sel;
				rd[EAT_OSC_RUN_BIT] = state_reg.osc_run_en;
			end
			EAT_IDX_MISSION_CFG: begin
				rd = EAT_MISSION_FILL | {2'b00, state_reg.mission_cfg};
			end
			EAT_IDX_ALARM_STAT: begin
				rd = EAT_ALARM_FILL;
				rd[EAT_BOR_BIT] = state_reg.bor_flag;
				rd[EAT_HHF_BIT] = state_reg.hum_high_flag;
				rd[EAT_HLF_BIT] = state_reg.hum_low_flag;
				rd[EAT_THF_BIT] = state_reg.temp_high_flag;
				rd[EAT_TLF_BIT] = state_reg.temp_low_flag;
			end
			default: begin
				rd = 8'h00;
			end
		endcase

		// Bus handshake: one wait cycle, then the answer edge
		case (state_reg.bus)
			EAT_BUS_IDLE: begin
				if (bus_req) begin
					state_next.bus = EAT_BUS_ACK;
					state_next.waitreq = 1'b0;
					state_next.rdata = AVS_READ ? rd : state_reg.rdata;
				end
			end
			EAT_BUS_ACK: begin
				// Write commits at the edge the master sees waitrequest low
				state_next.bus = EAT_BUS_IDLE;
				state_next.waitreq = 1'b1;
				if (AVS_WRITE && AVS_BYTEENABLE[0]) begin
					case (reg_idx)
						EAT_IDX_TEMP_LO_THR: begin
							state_next.temp_lo_thr = wr_byte;
						end
						EAT_IDX_TEMP_HI_THR: begin
							state_next.temp_hi_thr = wr_byte;
						end
						EAT_IDX_HUM_LO_THR: begin
							state_next.hum_lo_thr = wr_byte;
						end
						EAT_IDX_HUM_HI_THR: begin
							state_next.hum_hi_thr = wr_byte;
						end
						EAT_IDX_RATE_LO: begin
							if (!MISSION_ACTIVE) begin
								state_next.rate[7:0] = wr_byte;
							end
						end
						EAT_IDX_RATE_HI: begin
							if (!MISSION_ACTIVE) begin
								state_next.rate[13:8] = wr_byte[5:0];
							end
						end
						EAT_IDX_TEMP_CTRL: begin
							// Only the two enables are stored; upper bits stay zero
							if (!MISSION_ACTIVE) begin
								state_next.temp_high_alarm_en = wr_byte[EAT_HIGH_EN_BIT];
								state_next.temp_low_alarm_en = wr_byte[EAT_LOW_EN_BIT];
							end
						end
						EAT_IDX_HUM_CTRL: begin
							if (!MISSION_ACTIVE) begin
								state_next.hum_high_alarm_en = wr_byte[EAT_HIGH_EN_BIT];
								state_next.hum_low_alarm_en = wr_byte[EAT_LOW_EN_BIT];
							end
						end
						EAT_IDX_OSC_CTRL: begin
							if (!MISSION_ACTIVE) begin
								state_next.fast_sample_sel = wr_byte[EAT_FAST_BIT];
								state_next.osc_run_en = wr_byte[EAT_OSC_RUN_BIT];
							end
						end
						EAT_IDX_MISSION_CFG: begin
							if (!MISSION_ACTIVE) begin
								state_next.mission_cfg = wr_byte[5:0];
							end
						end
						default: begin
							state_next.rdata = state_reg.rdata;
						end
					endcase
				end
			end
			default: begin
				state_next.bus = EAT_BUS_IDLE;
				state_next.waitreq = 1'b1;
			end
		endcase

		// Conversion or mission start forces the oscillator to run over any write
		if (FORCED_CONV || MISSION_START) begin
			state_next.osc_run_en = 1'b1;
		end

		// Memory clear drops all alarm flags; a set below in the same cycle wins
		if (MEM_CLEAR) begin
			state_next.temp_low_flag = 1'b0;
			state_next.temp_high_flag = 1'b0;
			state_next.hum_low_flag = 1'b0;
			state_next.hum_high_flag = 1'b0;
			state_next.bor_flag = 1'b0;
		end

		// Temperature alarms use the conversion MSB only
		if (TEMP_CONV_VALID && MISSION_ACTIVE) begin
			if (state_reg.temp_high_alarm_en && TEMP_CONV_MSB >= state_reg.temp_hi_thr) begin
				state_next.temp_high_flag = 1'b1;
			end
			if (state_reg.temp_low_alarm_en && TEMP_CONV_MSB <= state_reg.temp_lo_thr) begin
				state_next.temp_low_flag = 1'b1;
			end
		end

		// Every humidity reading updates the result, forced or not
		if (HUM_CONV_VALID) begin
			state_next.hum_result = HUM_CONV_RESULT;
		end

		// Raw MSB against raw thresholds; no correction in hardware
		if (HUM_CONV_VALID && MISSION_ACTIVE) begin
			if (state_reg.hum_high_alarm_en && hum_msb_new >= state_reg.hum_hi_thr) begin
				state_next.hum_high_flag = 1'b1;
			end
			if (state_reg.hum_low_alarm_en && hum_msb_new <= state_reg.hum_lo_thr) begin
				state_next.hum_low_flag = 1'b1;
			end
		end

		// Log strobe: MSB always, low nibble only in wide format
		if (HUM_CONV_VALID && MISSION_ACTIVE && hum_log_en) begin
			state_next.log_wr = 1'b1;
			state_next.log_wide = hum_wide_format_sel;
			state_next.log_data = hum_wide_format_sel ? {HUM_CONV_RESULT, 4'h0} : {hum_msb_new, 8'h00};
		end

		state_next.alarm_any = state_next.temp_low_flag || state_next.temp_high_flag ||
			state_next.hum_low_flag || state_next.hum_high_flag;
	end

	// Single register stage; a battery reset marks the battery flag
	always_ff @(posedge REF_CLK or posedge RESET) begin
		if (RESET) begin
			state_reg.bus <= EAT_BUS_IDLE;
			state_reg.waitreq <= 1'b1;
			state_reg.rdata <= 8'h00;
			state_reg.temp_lo_thr <= EAT_THR_RESET;
			state_reg.temp_hi_thr <= EAT_THR_RESET;
			state_reg.hum_lo_thr <= EAT_THR_RESET;
			state_reg.hum_hi_thr <= EAT_THR_RESET;
			state_reg.hum_result <= 12'h000;
			state_reg.temp_high_alarm_en <= 1'b0;
			state_reg.temp_low_alarm_en <= 1'b0;
			state_reg.hum_high_alarm_en <= 1'b0;
			state_reg.hum_low_alarm_en <= 1'b0;
			state_reg.fast_sample_sel <= 1'b0;
			state_reg.osc_run_en <= 1'b0;
			state_reg.rate <= EAT_RATE_RESET;
			state_reg.mission_cfg <= EAT_MISSION_RESET;
			state_reg.temp_low_flag <= 1'b0;
			state_reg.temp_high_flag <= 1'b0;
			state_reg.hum_low_flag <= 1'b0;
			state_reg.hum_high_flag <= 1'b0;
			state_reg.bor_flag <= 1'b1;
			state_reg.log_wr <= 1'b0;
			state_reg.log_wide <= 1'b0;
			state_reg.log_data <= 16'h0000;
			state_reg.alarm_any <= 1'b0;
		end else begin
			state_reg <= state_next;
		end
	end

	// Outputs straight from the state flops
	assign AVS_READDATA = {24'h000000, state_reg.rdata};
	assign AVS_WAITREQUEST = state_reg.waitreq;
	assign OSC_RUN = state_reg.osc_run_en;
	assign FAST_SAMPLE = state_reg.fast_sample_sel;
	assign SAMPLE_DUE = timer_due;
	assign LOG_HUM_WR = state_reg.log_wr;
	assign LOG_HUM_WIDE = state_reg.log_wide;
	assign LOG_HUM_DATA = state_reg.log_data;
	assign ALARM_ANY = state_reg.alarm_any;

endmodule // eat_ctrl

// >>> rtl/eat_pkg.sv
package eat_pkg;

	// Clock rate and sample time base
	localparam int EAT_CLK_HZ = 20000000;
	localparam int EAT_SEC_UNIT_S = 1;
	localparam int EAT_SEC_CYCLES = EAT_CLK_HZ * EAT_SEC_UNIT_S;
	localparam logic [5:0] EAT_SEC_PER_MIN = 6'h3c;
	localparam int EAT_PRESC_W = 25;

	// Register indices; the bus byte address is four times the index
	localparam logic [9:0] EAT_IDX_RATE_LO = 10'h206;
	localparam logic [9:0] EAT_IDX_RATE_HI = 10'h207;
	localparam logic [9:0] EAT_IDX_TEMP_LO_THR = 10'h208;
	localparam logic [9:0] EAT_IDX_TEMP_HI_THR = 10'h209;
	localparam logic [9:0] EAT_IDX_HUM_LO_THR = 10'h20a;
	localparam logic [9:0] EAT_IDX_HUM_HI_THR = 10'h20b;
	localparam logic [9:0] EAT_IDX_HUM_RES_LSB = 10'h20e;
	localparam logic [9:0] EAT_IDX_HUM_RES_MSB = 10'h20f;
	localparam logic [9:0] EAT_IDX_TEMP_CTRL = 10'h210;
	localparam logic [9:0] EAT_IDX_HUM_CTRL = 10'h211;
	localparam logic [9:0] EAT_IDX_OSC_CTRL = 10'h212;
	localparam logic [9:0] EAT_IDX_MISSION_CFG = 10'h213;
	localparam logic [9:0] EAT_IDX_ALARM_STAT = 10'h214;

	// Field positions
	localparam int EAT_LOW_EN_BIT = 0;
	localparam int EAT_HIGH_EN_BIT = 1;
	localparam int EAT_OSC_RUN_BIT = 0;
	localparam int EAT_FAST_BIT = 1;
	localparam int EAT_HUM_LOG_BIT = 1;
	localparam int EAT_HUM_WIDE_BIT = 3;
	localparam int EAT_TLF_BIT = 0;
	localparam int EAT_THF_BIT = 1;
	localparam int EAT_HLF_BIT = 2;
	localparam int EAT_HHF_BIT = 3;
	localparam int EAT_BOR_BIT = 7;

	// Fixed bit patterns of unused register bits
	localparam logic [7:0] EAT_TEMP_CTRL_FILL = 8'h00;
	localparam logic [7:0] EAT_HUM_CTRL_FILL = 8'hfc;
	localparam logic [7:0] EAT_OSC_CTRL_FILL = 8'h00;
	localparam logic [7:0] EAT_MISSION_FILL = 8'hc0;
	localparam logic [7:0] EAT_ALARM_FILL = 8'h70;

	// Reset values and minimum interval
	localparam logic [7:0] EAT_THR_RESET = 8'h00;
	localparam logic [13:0] EAT_RATE_RESET = 14'h0000;
	localparam logic [5:0] EAT_MISSION_RESET = 6'h00;
	localparam logic [13:0] EAT_RATE_MIN = 14'h0001;

	// Bus answer states, one-hot
	typedef enum logic [1:0] {
		EAT_BUS_IDLE = 2'b01,
		EAT_BUS_ACK = 2'b10
	} eat_bus_e;

endpackage

// >>> rtl/eat_sample_timer.sv
`timescale 1ns/10ps
module eat_sample_timer import eat_pkg::*; #(
	parameter int SEC_CYCLES = EAT_SEC_CYCLES
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic run_en,
	input wire logic fast_sel,
	input wire logic [13:0] interval,
	output logic sample_due
);

	typedef struct packed {
		logic [EAT_PRESC_W-1:0] presc;
		logic [5:0] sec_cnt;
		logic [13:0] unit_cnt;
		logic due;
	} eat_timer_s;

	eat_timer_s state_reg;
	eat_timer_s state_next;

	// Second prescaler, minute divider and interval counter
	always_comb begin
		logic sec_tick;
		logic unit_tick;
		logic [13:0] target;
		sec_tick = 1'b0;
		unit_tick = 1'b0;
		target = (interval == 14'h0000) ? EAT_RATE_MIN : interval;
		state_next = state_reg;
		state_next.due = 1'b0;
		if (!run_en) begin
			// Stopped oscillator holds the time base at zero
			state_next.presc = '0;
			state_next.sec_cnt = '0;
			state_next.unit_cnt = '0;
		end else begin
			if (state_reg.presc == EAT_PRESC_W'(SEC_CYCLES - 1)) begin
				state_next.presc = '0;
				sec_tick = 1'b1;
			end else begin
				state_next.presc = state_reg.presc + 1'b1;
			end
			if (sec_tick) begin
				if (state_reg.sec_cnt == EAT_SEC_PER_MIN - 6'h01) begin
					state_next.sec_cnt = '0;
				end else begin
					state_next.sec_cnt = state_reg.sec_cnt + 1'b1;
				end
			end
			// Seconds when fast, minutes otherwise
			unit_tick = fast_sel ? sec_tick : (sec_tick && state_reg.sec_cnt == EAT_SEC_PER_MIN - 6'h01);
			if (unit_tick) begin
				if (state_reg.unit_cnt + 14'h0001 >= target) begin
					state_next.unit_cnt = '0;
					state_next.due = 1'b1;
				end else begin
					state_next.unit_cnt = state_reg.unit_cnt + 14'h0001;
				end
			end
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			state_reg <= '0;
		end else begin
			state_reg <= state_next;
		end
	end

	assign sample_due = state_reg.due;

endmodule // eat_sample_timer

// >>> sim/eat_ctrl_monitor.sv
`timescale 1ns/10ps
// Port-level checks of the bus handshake, alarm flags, log port and timer
module eat_ctrl_monitor import eat_pkg::*; #(
	parameter int SEC_CYCLES = EAT_SEC_CYCLES
) (
	input wire logic REF_CLK,
	input wire logic RESET,
	input wire logic AVS_READ,
	input wire logic AVS_WRITE,
	input wire logic [31:0] AVS_READDATA,
	input wire logic AVS_WAITREQUEST,
	input wire logic MISSION_ACTIVE,
	input wire logic MISSION_START,
	input wire logic FORCED_CONV,
	input wire logic MEM_CLEAR,
	input wire logic TEMP_CONV_VALID,
	input wire logic HUM_CONV_VALID,
	input wire logic [11:0] HUM_CONV_RESULT,
	input wire logic OSC_RUN,
	input wire logic SAMPLE_DUE,
	input wire logic LOG_HUM_WR,
	input wire logic LOG_HUM_WIDE,
	input wire logic [15:0] LOG_HUM_DATA,
	input wire logic ALARM_ANY
);
	default clocking @(posedge REF_CLK); endclocking
	default disable iff (RESET);

	// Bus answers after exactly one wait cycle and only for one cycle
	bus_answer_a: assert property ((AVS_READ || AVS_WRITE) && AVS_WAITREQUEST |=> !AVS_WAITREQUEST ##1 AVS_WAITREQUEST)
		else $error("bus answer timing off");
	read_upper_a: assert property (!AVS_WAITREQUEST |-> AVS_READDATA[31:8] == 24'h000000)
		else $error("read data upper bits not zero");
	// An alarm can only come from a conversion during a mission
	alarm_cause_a: assert property ($rose(ALARM_ANY) |-> $past(MISSION_ACTIVE && (TEMP_CONV_VALID || HUM_CONV_VALID)))
		else $error("alarm raised without a mission conversion");
	alarm_sticky_a: assert property (ALARM_ANY && !MEM_CLEAR |=> ALARM_ANY)
		else $error("alarm flag dropped without clear");
	alarm_clear_a: assert property (MEM_CLEAR && !TEMP_CONV_VALID && !HUM_CONV_VALID |=> !ALARM_ANY)
		else $error("alarm flag survived clear");
	// Log writes follow a mission humidity reading, high byte always
	log_cause_a: assert property (LOG_HUM_WR |-> $past(HUM_CONV_VALID && MISSION_ACTIVE))
		else $error("log write without mission reading");
	log_msb_a: assert property (LOG_HUM_WR |-> LOG_HUM_DATA[15:8] == $past(HUM_CONV_RESULT[11:4]))
		else $error("logged high byte wrong");
	log_lsb_a: assert property (LOG_HUM_WR |->
		LOG_HUM_DATA[7:0] == (LOG_HUM_WIDE ? {$past(HUM_CONV_RESULT[3:0]), 4'h0} : 8'h00))
		else $error("logged low byte wrong");
	osc_start_a: assert property (FORCED_CONV || MISSION_START |=> OSC_RUN)
		else $error("oscillator not started");
	due_single_a: assert property (SAMPLE_DUE |=> !SAMPLE_DUE)
		else $error("sample strobe longer than one cycle");

	// Main scenarios reached
	wide_log_c: cover property (LOG_HUM_WR && LOG_HUM_WIDE);
	narrow_log_c: cover property (LOG_HUM_WR && !LOG_HUM_WIDE);
	alarm_c: cover property ($rose(ALARM_ANY));
	due_c: cover property (SAMPLE_DUE);
endmodule // eat_ctrl_monitor

// >>> sim/eat_ctrl_tb.sv
`timescale 1ns/10ps
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin err_count++; \
	$display("wrong value at %0t: got %h expected %h", $time, g, e); end end
module eat_ctrl_tb import eat_pkg::*; ;
	// Short second so minute intervals stay a few hundred cycles
	localparam int SEC = 4;
	logic REF_CLK = 1'b0;
	logic RESET = 1'b1;
	logic [11:0] addr = 12'h000;
	logic rd_s = 1'b0;
	logic wr_s = 1'b0;
	logic [31:0] wdata = 32'h0;
	logic [3:0] be = 4'hf;
	logic mission = 1'b0;
	logic tv = 1'b0;
	logic hv = 1'b0;
	logic [2:0] ev = 3'h0;
	logic [7:0] tmsb = 8'h00;
	logic [11:0] hres = 12'h000;
	logic [31:0] rdata;
	logic waitreq, osc, fast, due, lwr, lwide, alarm;
	logic [15:0] ldata;
	logic [7:0] thr [4] = '{8'h3e, 8'h85, 8'h58, 8'hb5};
	int err_count = 0;
	int comparisons = 0;
	int cycles = 0;

	always #25 REF_CLK = ~REF_CLK;

	eat_ctrl #(.SEC_CYCLES(SEC)) u_eat_ctrl (.REF_CLK(REF_CLK), .RESET(RESET), .AVS_ADDRESS(addr),
		.AVS_READ(rd_s), .AVS_WRITE(wr_s), .AVS_WRITEDATA(wdata), .AVS_BYTEENABLE(be), .AVS_READDATA(rdata),
		.AVS_WAITREQUEST(waitreq), .MISSION_ACTIVE(mission), .MISSION_START(ev[2]), .FORCED_CONV(ev[1]),
		.MEM_CLEAR(ev[0]), .TEMP_CONV_VALID(tv), .TEMP_CONV_MSB(tmsb), .HUM_CONV_VALID(hv),
		.HUM_CONV_RESULT(hres), .OSC_RUN(osc), .FAST_SAMPLE(fast), .SAMPLE_DUE(due), .LOG_HUM_WR(lwr),
		.LOG_HUM_WIDE(lwide), .LOG_HUM_DATA(ldata), .ALARM_ANY(alarm));

	task test_done;
		if (err_count == 0 && comparisons > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	// A hang anywhere ends the run as a failure
	always @(posedge REF_CLK) begin
		cycles++;
		if (cycles == 5000) begin
			err_count++;
			test_done;
		end
	end

	// One bus access, held until waitrequest is seen low
	task bus(input logic w, input logic [9:0] idx, input logic [7:0] d, output logic [7:0] q);
		@(posedge REF_CLK);
		addr <= {idx, 2'b00};
		wdata <= {24'h0, d};
		wr_s <= w;
		rd_s <= !w;
		do @(posedge REF_CLK); while (waitreq !== 1'b0);
		q = rdata[7:0];
		wr_s <= 1'b0;
		rd_s <= 1'b0;
	endtask

	task wr(input logic [9:0] idx, input logic [7:0] d);
		logic [7:0] q;
		bus(1'b1, idx, d, q);
	endtask

	task rc(input logic [9:0] idx, input logic [7:0] e);
		logic [7:0] q;
		bus(1'b0, idx, 8'h00, q);
		`CHK(q, e)
	endtask

	// One-cycle conversion strobe; outputs settle just after the taking edge
	task conv(input logic t, input logic [11:0] v);
		@(posedge REF_CLK);
		tv <= t;
		hv <= !t;
		tmsb <= v[7:0];
		hres <= v;
		@(posedge REF_CLK);
		tv <= 1'b0;
		hv <= 1'b0;
		#1;
	endtask

	task evt(input logic [2:0] e);
		@(posedge REF_CLK);
		ev <= e;
		@(posedge REF_CLK);
		ev <= 3'h0;
		#1;
	endtask

	// Cycles between two successive sample strobes
	task meas(input int e);
		int n;
		n = 0;
		@(negedge REF_CLK);
		while (due !== 1'b1) @(negedge REF_CLK);
		do begin
			@(negedge REF_CLK);
			n++;
		end while (due !== 1'b1);
		`CHK(n, e)
	endtask

	initial begin
		repeat (6) @(posedge REF_CLK);
		RESET <= 1'b0;
		rc(EAT_IDX_ALARM_STAT, 8'hf0);
		rc(EAT_IDX_TEMP_CTRL, 8'h00);
		rc(EAT_IDX_HUM_CTRL, 8'hfc);
		wr(EAT_IDX_TEMP_CTRL, 8'hff);
		rc(EAT_IDX_TEMP_CTRL, 8'h03);
		wr(EAT_IDX_HUM_CTRL, 8'h00);
		rc(EAT_IDX_HUM_CTRL, 8'hfc);
		wr(EAT_IDX_HUM_CTRL, 8'hff);
		wr(EAT_IDX_OSC_CTRL, 8'hfc);
		rc(EAT_IDX_OSC_CTRL, 8'h00);
		for (int i = 0; i < 4; i++) wr(EAT_IDX_TEMP_LO_THR + 10'(i), thr[i]);
		for (int i = 0; i < 4; i++) rc(EAT_IDX_TEMP_LO_THR + 10'(i), thr[i]);
		be <= 4'he;
		wr(EAT_IDX_HUM_LO_THR, 8'h11);
		be <= 4'hf;
		rc(EAT_IDX_HUM_LO_THR, 8'h58);
		rc(10'h300, 8'h00);
		wr(EAT_IDX_MISSION_CFG, 8'h0a);
		rc(EAT_IDX_MISSION_CFG, 8'hca);
		wr(EAT_IDX_RATE_LO, 8'h00);
		wr(EAT_IDX_OSC_CTRL, 8'h01);
		#1;
		`CHK({osc, fast}, 2'b10)
		// Wide-format mission with all alarms enabled
		@(posedge REF_CLK);
		mission <= 1'b1;
		wr(EAT_IDX_TEMP_CTRL, 8'h00);
		rc(EAT_IDX_TEMP_CTRL, 8'h03);
		wr(EAT_IDX_OSC_CTRL, 8'h00);
		rc(EAT_IDX_OSC_CTRL, 8'h01);
		meas(60 * SEC);
		conv(1'b0, 12'hb4f);
		`CHK({lwr, lwide, ldata}, 18'h3b4f0)
		rc(EAT_IDX_ALARM_STAT, 8'hf0);
		conv(1'b0, 12'hb5c);
		rc(EAT_IDX_HUM_RES_MSB, 8'hb5);
		rc(EAT_IDX_HUM_RES_LSB, 8'hc0);
		rc(EAT_IDX_ALARM_STAT, 8'hf8);
		conv(1'b0, 12'h580);
		rc(EAT_IDX_ALARM_STAT, 8'hfc);
		conv(1'b1, 12'h03e);
		rc(EAT_IDX_ALARM_STAT, 8'hfd);
		conv(1'b1, 12'h085);
		rc(EAT_IDX_ALARM_STAT, 8'hff);
		conv(1'b0, 12'h700);
		conv(1'b1, 12'h060);
		rc(EAT_IDX_ALARM_STAT, 8'hff);
		`CHK(alarm, 1'b1)
		// Narrow-format mission, temperature alarms disabled
		mission <= 1'b0;
		wr(EAT_IDX_TEMP_CTRL, 8'h00);
		wr(EAT_IDX_MISSION_CFG, 8'h02);
		wr(EAT_IDX_OSC_CTRL, 8'h03);
		wr(EAT_IDX_RATE_LO, 8'h02);
		evt(3'b001);
		rc(EAT_IDX_ALARM_STAT, 8'h70);
		`CHK({alarm, fast}, 2'b01)
		mission <= 1'b1;
		meas(2 * SEC);
		conv(1'b0, 12'h673);
		`CHK({lwr, lwide, ldata}, 18'h26700)
		conv(1'b1, 12'h03e);
		conv(1'b1, 12'h085);
		rc(EAT_IDX_ALARM_STAT, 8'h70);
		// Logging disabled: a mission reading is not logged
		mission <= 1'b0;
		wr(EAT_IDX_MISSION_CFG, 8'h08);
		mission <= 1'b1;
		conv(1'b0, 12'h673);
		`CHK(lwr, 1'b0)
		// Forced conversion outside a mission: result only
		@(posedge REF_CLK);
		mission <= 1'b0;
		conv(1'b0, 12'hb5c);
		`CHK(lwr, 1'b0)
		rc(EAT_IDX_HUM_RES_MSB, 8'hb5);
		rc(EAT_IDX_ALARM_STAT, 8'h70);
		wr(EAT_IDX_OSC_CTRL, 8'h00);
		#1;
		`CHK(osc, 1'b0)
		evt(3'b010);
		`CHK(osc, 1'b1)
		wr(EAT_IDX_OSC_CTRL, 8'h00);
		evt(3'b100);
		rc(EAT_IDX_OSC_CTRL, 8'h01);
		test_done;
	end
endmodule // eat_ctrl_tb

// Checker beside every instance of the block
bind eat_ctrl eat_ctrl_monitor #(.SEC_CYCLES(SEC_CYCLES)) u_eat_ctrl_monitor (.REF_CLK(REF_CLK), .RESET(RESET),
	.AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE), .AVS_READDATA(AVS_READDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST),
	.MISSION_ACTIVE(MISSION_ACTIVE), .MISSION_START(MISSION_START), .FORCED_CONV(FORCED_CONV),
	.MEM_CLEAR(MEM_CLEAR), .TEMP_CONV_VALID(TEMP_CONV_VALID), .HUM_CONV_VALID(HUM_CONV_VALID),
	.HUM_CONV_RESULT(HUM_CONV_RESULT), .OSC_RUN(OSC_RUN), .SAMPLE_DUE(SAMPLE_DUE), .LOG_HUM_WR(LOG_HUM_WR),
	.LOG_HUM_WIDE(LOG_HUM_WIDE), .LOG_HUM_DATA(LOG_HUM_DATA), .ALARM_ANY(ALARM_ANY));
